// ==== src/ued_event_dma.sv ====
// Event source flags, in-service tracking and DMA requests of the emulation.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Idle non-empty transmit FIFO below trigger past timeout sets bit 5; access clears.
// - Non-FIFO: host receive read sets bit 4; processor receive write clears.
// - FIFO mode: host emptying receive FIFO sets bit 4; processor write clears.
// - Host modem control write sets bit 3; processor read of it clears.
// - Host line control write sets bit 2; processor read of it clears.
// - Host write of either divisor byte sets bit 1.
// - Bit 1 clears once every pending divisor byte has been read back.
// - Host FIFO control write or a transmit sets bit 0; processor read clears.
// - Single mode: receive DMA request while receive FIFO holds any byte.
// - Single mode: transmit DMA request while transmit FIFO is empty.
// - Multi mode: receive request rises at trigger, falls at empty.
// - Multi mode: transmit request while transmit FIFO is not full.
// - FIFO control bit 3 selects multi-byte DMA; zero, the default, single.
// - Processor DMA requests are the inverse of holding-empty and data-ready status bits.
// - With delay timers on, processor requests use the shadow status bits.
// - Host holding write sets bit 6, processor read clears; FIFO: trigger.
// - Bit 7 is OR of in-service bits; writing 1 drops the highest.
module ued_event_dma
    import ued_pkg::*;
#(
    parameter int TX_IDLE_CYCLES = TX_IDLE_CYCLES_DEF,
    parameter int NUM_IUS        = NUM_IUS_DEF
) (
    input  wire logic               core_clk,
    input  wire logic               reset,
    input  wire ued_host_acc_t      host_acc,
    input  wire ued_cpu_acc_t       cpu_acc,
    input  wire ued_fifo_st_t       fifo_st,
    input  wire logic [NUM_IUS-1:0] ius_set,
    output logic [NUM_IUS-1:0]      ius_bits,
    output logic [EVT_W-1:0]        host_event_source,
    output logic                    host_dma_multi,
    output ued_dma_t                dma_req,
    output logic                    evt_rd_ready,
    output logic                    evt_rd_valid,
    input  wire logic               evt_rd_accept,
    output logic [EVT_W-1:0]        evt_rd_data
);

    localparam int TMR_W = $clog2(TX_IDLE_CYCLES + 1);
    localparam logic [TMR_W-1:0] TMR_LOAD = TMR_W'(TX_IDLE_CYCLES);
    localparam logic [TMR_W-1:0] TMR_ONE  = {{(TMR_W-1){1'b0}}, 1'b1};
    localparam logic [TMR_W-1:0] TMR_ZERO = {TMR_W{1'b0}};

    logic [EVT_FLAG_W-1:0] flags_r;
    logic [NUM_IUS-1:0]    ius_r;
    logic [NUM_IUS-1:0]    ius_nxt;
    logic [NUM_IUS-1:0]    ius_clr;
    logic [NUM_IUS-1:0]    ius_lower;
    logic                  ius_drop;
    logic                  ius_any_r;
    logic                  div_lo_pend_r;
    logic                  div_hi_pend_r;
    logic                  div_lo_nxt;
    logic                  div_hi_nxt;
    logic [TMR_W-1:0]      tmr_r;
    logic                  tmr_reload;
    logic                  tx_idle_fire;
    logic                  rx_empty_d_r;
    logic                  rx_emptied;
    logic                  multi_r;
    logic                  host_rx_req_r;
    logic                  host_tx_req_r;
    logic                  cpu_rx_req_r;
    logic                  cpu_tx_req_r;
    logic                  holding_empty_flag_sel;
    logic                  dr_sel;
    logic [EVT_W-1:0]      evt_view;

    assign evt_view = {ius_any_r, flags_r};

    // Transmit idle timer: restarted by any FIFO access or when the fill
    // level leaves the band between empty and the trigger level.
    assign tmr_reload   = fifo_st.tx_access || fifo_st.tx_empty ||
                          !fifo_st.tx_below_trig;
    assign tx_idle_fire = !tmr_reload && (tmr_r == TMR_ONE);

    always_ff @(posedge core_clk) begin
        if (reset) begin
            tmr_r <= TMR_LOAD;
        end else if (tmr_reload) begin
            tmr_r <= TMR_LOAD;
        end else if (tmr_r != TMR_ZERO) begin
            tmr_r <= tmr_r - TMR_ONE;
        end
    end

    // The emptied event is taken from the edge of the empty level, since the
    // processor never drains the receive FIFO and only the host can cause it.
    assign rx_emptied = fifo_st.rx_empty && !rx_empty_d_r;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            rx_empty_d_r <= 1'b1;
        end else begin
            rx_empty_d_r <= fifo_st.rx_empty;
        end
    end

    // Divisor bytes are tracked apart so that reading one byte leaves the
    // flag up while the other byte is still unread.
    always_comb begin
        div_lo_nxt = div_lo_pend_r;
        div_hi_nxt = div_hi_pend_r;
        if (cpu_acc.rd_dll) begin
            div_lo_nxt = 1'b0;
        end
        if (cpu_acc.rd_dlm) begin
            div_hi_nxt = 1'b0;
        end
        if (host_acc.wr_dll) begin
            div_lo_nxt = 1'b1;
        end
        if (host_acc.wr_dlm) begin
            div_hi_nxt = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            div_lo_pend_r <= 1'b0;
            div_hi_pend_r <= 1'b0;
        end else begin
            div_lo_pend_r <= div_lo_nxt;
            div_hi_pend_r <= div_hi_nxt;
        end
    end

    // Event flags. In every flag a set in the same cycle as its clear wins.
    // Of processor writes only the receive buffer write reaches these bits.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            flags_r <= EVT_FLAGS_RST;
        end else begin
            flags_r[EVT_DIV_BIT] <= div_lo_nxt || div_hi_nxt;

            if (host_acc.wr_fcr || fifo_st.tx_occurred) begin
                flags_r[EVT_FCR_BIT] <= 1'b1;
            end else if (cpu_acc.rd_fcr) begin
                flags_r[EVT_FCR_BIT] <= 1'b0;
            end

            if (host_acc.wr_lcr) begin
                flags_r[EVT_LCR_BIT] <= 1'b1;
            end else if (cpu_acc.rd_lcr) begin
                flags_r[EVT_LCR_BIT] <= 1'b0;
            end

            if (host_acc.wr_mcr) begin
                flags_r[EVT_MCR_BIT] <= 1'b1;
            end else if (cpu_acc.rd_mcr) begin
                flags_r[EVT_MCR_BIT] <= 1'b0;
            end

            if (fifo_st.fifo_mode) begin
                if (rx_emptied) begin
                    flags_r[EVT_RBR_BIT] <= 1'b1;
                end else if (cpu_acc.wr_rbr) begin
                    flags_r[EVT_RBR_BIT] <= 1'b0;
                end
            end else begin
                if (host_acc.rd_rbr) begin
                    flags_r[EVT_RBR_BIT] <= 1'b1;
                end else if (cpu_acc.wr_rbr) begin
                    flags_r[EVT_RBR_BIT] <= 1'b0;
                end
            end

            if (tx_idle_fire) begin
                flags_r[EVT_TXTO_BIT] <= 1'b1;
            end else if (fifo_st.tx_access) begin
                flags_r[EVT_TXTO_BIT] <= 1'b0;
            end

            // In FIFO mode the flag follows the fill level against trigger.
            if (fifo_st.fifo_mode) begin
                flags_r[EVT_THR_BIT] <= fifo_st.tx_at_trig;
            end else if (host_acc.wr_thr) begin
                flags_r[EVT_THR_BIT] <= 1'b1;
            end else if (cpu_acc.rd_thr) begin
                flags_r[EVT_THR_BIT] <= 1'b0;
            end
        end
    end

    // In-service bits: bit 0 has the highest priority. A new entry into
    // service wins over a simultaneous end-of-service write.
    assign ius_drop = cpu_acc.wr_evt && cpu_acc.wdata[EVT_IUS_BIT];

    // Only the lowest set index drops, so every bit below it must be clear.
    for (genvar i = 0; i < NUM_IUS; i++) begin : g_ius
        if (i == 0) begin : g_top
            assign ius_lower[i] = 1'b0;
        end else begin : g_rest
            assign ius_lower[i] = |ius_r[i-1:0];
        end
        assign ius_clr[i] = ius_drop && ius_r[i] && !ius_lower[i];
    end
    assign ius_nxt = (ius_r & ~ius_clr) | ius_set;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            ius_r <= {NUM_IUS{1'b0}};
        end else begin
            ius_r <= ius_nxt;
        end
    end

    // The summary bit is registered from the next state so that it never
    // lags the in-service bits it stands for.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ius_any_r <= 1'b0;
        end else begin
            ius_any_r <= |ius_nxt;
        end
    end

    // Host DMA mode is caught from each host write of the FIFO control byte.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            multi_r <= DMA_MULTI_RST;
        end else if (host_acc.wr_fcr) begin
            multi_r <= host_acc.wdata[FCR_DMA_MODE_BIT];
        end
    end

    // Host side DMA requests. In multi mode the receive request holds from
    // the trigger level down to empty, so the host can drain in bursts.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            host_rx_req_r <= 1'b0;
        end else if (!multi_r) begin
            host_rx_req_r <= !fifo_st.rx_empty;
        end else if (fifo_st.rx_empty) begin
            host_rx_req_r <= 1'b0;
        end else if (fifo_st.rx_at_trig) begin
            host_rx_req_r <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            host_tx_req_r <= 1'b0;
        end else if (multi_r) begin
            host_tx_req_r <= !fifo_st.tx_full;
        end else begin
            host_tx_req_r <= fifo_st.tx_empty;
        end
    end

    // Processor side DMA requests from the immediate or the delayed status.
    assign holding_empty_flag_sel = fifo_st.delay_tmr_en ? fifo_st.holding_empty_sh :
                                             fifo_st.holding_empty;
    assign dr_sel   = fifo_st.delay_tmr_en ? fifo_st.data_ready_sh :
                                             fifo_st.data_ready;

    // Both status bits are high when the processor has nothing to move,
    // so each request is the inverse of its selected bit.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cpu_tx_req_r <= 1'b0;
        end else begin
            cpu_tx_req_r <= !holding_empty_flag_sel;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            cpu_rx_req_r <= 1'b0;
        end else begin
            cpu_rx_req_r <= !dr_sel;
        end
    end

    // A processor read of the event register is snapshotted into a small
    // buffer so that a stalled reader loses no value; the reader must hold
    // further reads off while evt_rd_ready is low.
    ued_buf2 #(
        .W (EVT_W)
    ) u_rd_buf (
        .core_clk  (core_clk),
        .reset     (reset),
        .in_valid  (cpu_acc.rd_evt),
        .in_ready  (evt_rd_ready),
        .in_data   (evt_view),
        .out_valid (evt_rd_valid),
        .out_ready (evt_rd_accept),
        .out_data  (evt_rd_data)
    );

    assign ius_bits            = ius_r;
    assign host_event_source   = evt_view;
    assign host_dma_multi      = multi_r;
    assign dma_req.host_rx_req = host_rx_req_r;
    assign dma_req.host_tx_req = host_tx_req_r;
    assign dma_req.cpu_rx_req  = cpu_rx_req_r;
    assign dma_req.cpu_tx_req  = cpu_tx_req_r;

endmodule // ued_event_dma

`default_nettype wire

// ==== src/ued_pkg.sv ====
// Shared constants and carrier types for the UART emulation event and DMA logic.
package ued_pkg;

    // Bit positions inside the host event source register.
    localparam int EVT_W         = 8;
    localparam int EVT_FCR_BIT   = 0;
    localparam int EVT_DIV_BIT   = 1;
    localparam int EVT_LCR_BIT   = 2;
    localparam int EVT_MCR_BIT   = 3;
    localparam int EVT_RBR_BIT   = 4;
    localparam int EVT_TXTO_BIT  = 5;
    localparam int EVT_THR_BIT   = 6;
    localparam int EVT_IUS_BIT   = 7;
    localparam int EVT_FLAG_W    = 7;

    // Reset values.
    localparam logic [6:0] EVT_FLAGS_RST = 7'h00;
    localparam logic       DMA_MULTI_RST = 1'b0;

    // Host DMA mode select inside the written FIFO control byte.
    localparam int FCR_DMA_MODE_BIT = 3;

    // Idle time of the transmit FIFO, in core clock cycles.
    localparam int TX_IDLE_CYCLES_DEF = 256;

    // Number of in-service sources on the interrupt chain.
    localparam int NUM_IUS_DEF = 8;

    // One-cycle access strobes from the host side.
    typedef struct packed {
        logic       wr_thr;
        logic       rd_rbr;
        logic       wr_mcr;
        logic       wr_lcr;
        logic       wr_dll;
        logic       wr_dlm;
        logic       wr_fcr;
        logic [7:0] wdata;
    } ued_host_acc_t;

    // One-cycle access strobes from the processor side.
    typedef struct packed {
        logic       rd_thr;
        logic       wr_rbr;
        logic       rd_mcr;
        logic       rd_lcr;
        logic       rd_dll;
        logic       rd_dlm;
        logic       rd_fcr;
        logic       rd_evt;
        logic       wr_evt;
        logic [7:0] wdata;
    } ued_cpu_acc_t;

    // Fill and status levels of the FIFOs and the line status bits.
    typedef struct packed {
        logic fifo_mode;
        logic tx_empty;
        logic tx_full;
        logic tx_below_trig;
        logic tx_at_trig;
        logic tx_access;
        logic tx_occurred;
        logic rx_empty;
        logic rx_at_trig;
        logic holding_empty;
        logic data_ready;
        logic holding_empty_sh;
        logic data_ready_sh;
        logic delay_tmr_en;
    } ued_fifo_st_t;

    // DMA request lines toward both sides.
    typedef struct packed {
        logic host_rx_req;
        logic host_tx_req;
        logic cpu_rx_req;
        logic cpu_tx_req;
    } ued_dma_t;

endpackage

// ==== src/ued_buf2.sv ====
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none

module ued_buf2 #(
    parameter int W = 8
) (
    input  wire logic         core_clk,
    input  wire logic         reset,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);

    logic [W-1:0] d0_r;
    logic [W-1:0] d1_r;
    logic         v0_r;
    logic         v1_r;
    logic         rdy_r;
    logic         push;
    logic         pop;
    logic         v1_nxt;

    assign push      = in_valid && rdy_r;
    assign pop       = v0_r && out_ready;
    assign in_ready  = rdy_r;
    assign out_valid = v0_r;
    assign out_data  = d0_r;

    always_comb begin
        v1_nxt = v1_r;
        if (push && v0_r && !pop) begin
            v1_nxt = 1'b1;
        end else if (pop && !push) begin
            v1_nxt = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            v0_r  <= 1'b0;
            v1_r  <= 1'b0;
            rdy_r <= 1'b1;
        end else begin
            v0_r  <= (v0_r && !pop) || push || v1_r;
            v1_r  <= v1_nxt;
            rdy_r <= !v1_nxt;
        end
    end

    // The head takes the second entry on a pop so that order is kept.
    always_ff @(posedge core_clk) begin
        if (pop && v1_r) begin
            d0_r <= d1_r;
        end else if (push && (!v0_r || pop)) begin
            d0_r <= in_data;
        end
        if (push && v0_r && !(pop && !v1_r)) begin
            d1_r <= in_data;
        end
    end

endmodule // ued_buf2

`default_nettype wire

// ==== testbench/ued_event_dma_asserts.sv ====
// Port-level checker for the event flag and DMA request block.
`timescale 1ns/1ps
`default_nettype none
module ued_event_dma_asserts
    import ued_pkg::*;
(
    input wire logic             core_clk,
    input wire logic             reset,
    input wire ued_host_acc_t    host_acc,
    input wire ued_cpu_acc_t     cpu_acc,
    input wire ued_fifo_st_t     fifo_st,
    input wire logic [EVT_W-1:0] host_event_source,
    input wire logic             host_dma_multi,
    input wire ued_dma_t         dma_req
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    AST_LCR_SET: assert property (host_acc.wr_lcr |=>
        host_event_source[EVT_LCR_BIT]) else $error("lcr flag not set");
    AST_MCR_CLR: assert property (cpu_acc.rd_mcr && !host_acc.wr_mcr |=>
        !host_event_source[EVT_MCR_BIT]) else $error("mcr flag kept");
    AST_FCR_SET: assert property (host_acc.wr_fcr || fifo_st.tx_occurred
        |=> host_event_source[EVT_FCR_BIT]) else $error("fcr flag not set");
    AST_DIV_SET: assert property (host_acc.wr_dll || host_acc.wr_dlm
        |=> host_event_source[EVT_DIV_BIT]) else $error("div flag not set");
    AST_MODE: assert property (host_acc.wr_fcr |=>
        host_dma_multi == $past(host_acc.wdata[FCR_DMA_MODE_BIT]))
        else $error("dma mode wrong");
    AST_SGL_TX: assert property (!host_dma_multi && !host_acc.wr_fcr |=>
        dma_req.host_tx_req == $past(fifo_st.tx_empty))
        else $error("single tx request wrong");
    AST_MUL_RX: assert property (host_dma_multi && !host_acc.wr_fcr
        && fifo_st.rx_empty |=> !dma_req.host_rx_req)
        else $error("multi rx request held");
    AST_CPU_TX: assert property (!fifo_st.delay_tmr_en |=>
        dma_req.cpu_tx_req == !$past(fifo_st.holding_empty))
        else $error("cpu tx request wrong");
    AST_CPU_SH: assert property (fifo_st.delay_tmr_en |=>
        dma_req.cpu_rx_req == !$past(fifo_st.data_ready_sh) &&
        dma_req.cpu_tx_req == !$past(fifo_st.holding_empty_sh))
        else $error("cpu shadow request wrong");
endmodule // ued_event_dma_asserts

bind ued_event_dma ued_event_dma_asserts ued_event_dma_asserts_inst (
    .core_clk(core_clk), .reset(reset), .host_acc(host_acc),
    .cpu_acc(cpu_acc), .fifo_st(fifo_st),
    .host_event_source(host_event_source),
    .host_dma_multi(host_dma_multi), .dma_req(dma_req)
);
`default_nettype wire

// ==== testbench/ued_far_model.sv ====
// Behavioural far side: FIFO fill levels and status bits seen by the block.
`timescale 1ns/1ps
`default_nettype none
module ued_far_model
    import ued_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic [3:0] fm,
    input  wire logic       fifo_mode,
    input  wire logic       dly_en,
    input  wire logic       sh_upd,
    output ued_fifo_st_t    fifo_st
);
    // Sixteen deep FIFOs, trigger four; fm is tx push, tx pop, rx push, rx pop.
    // Shadows move only on reset or sh_upd, so a stale one exposes a wrong source pick.
    logic [4:0] tx_r;
    logic [4:0] rx_r;
    logic       he_sh_r;
    logic       dr_sh_r;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            tx_r <= 5'h00;
            rx_r <= 5'h00;
        end else begin
            tx_r <= tx_r + 5'(fm[0]) - 5'(fm[1]);
            rx_r <= rx_r + 5'(fm[2]) - 5'(fm[3]);
        end
    end
    always_ff @(posedge core_clk) begin
        if (reset || sh_upd) begin
            he_sh_r <= (tx_r == 5'h00);
            dr_sh_r <= (rx_r == 5'h10);
        end
    end
    assign fifo_st = '{fifo_mode, tx_r == 5'h00, tx_r == 5'h10, tx_r < 5'h04,
        tx_r >= 5'h04, fm[0] | fm[1], fm[1], rx_r == 5'h00, rx_r >= 5'h04,
        tx_r == 5'h00, rx_r == 5'h10, he_sh_r, dr_sh_r, dly_en};
endmodule // ued_far_model
`default_nettype wire

// ==== testbench/test_ued_event_dma.sv ====
// Self-checking bench for the event flag and DMA request block.
`timescale 1ns/1ps
`default_nettype none
module test_ued_event_dma
    import ued_pkg::*;
;
    logic          core_clk;
    logic          reset;
    ued_host_acc_t host_acc;
    ued_cpu_acc_t  cpu_acc;
    ued_fifo_st_t  fifo_st;
    ued_dma_t      dma_req;
    logic [7:0]    ius_set;
    logic [7:0]    ius_bits;
    logic [7:0]    hes;
    logic [7:0]    rd_data;
    logic [3:0]    fm;
    logic          multi;
    logic          rd_ready;
    logic          rd_valid;
    logic          rd_accept;
    logic          fifo_mode;
    logic          dly_en;
    logic          sh_upd;
    int            failures;
    int            checks;
    int            cyc;

    ued_event_dma #(.TX_IDLE_CYCLES(4), .NUM_IUS(8)) ued_event_dma_inst (
        .core_clk(core_clk), .reset(reset), .host_acc(host_acc),
        .cpu_acc(cpu_acc), .fifo_st(fifo_st), .ius_set(ius_set),
        .ius_bits(ius_bits), .host_event_source(hes),
        .host_dma_multi(multi), .dma_req(dma_req), .evt_rd_ready(rd_ready),
        .evt_rd_valid(rd_valid), .evt_rd_accept(rd_accept),
        .evt_rd_data(rd_data));
    ued_far_model ued_far_model_inst (.core_clk(core_clk), .reset(reset),
        .fm(fm), .fifo_mode(fifo_mode), .dly_en(dly_en), .sh_upd(sh_upd),
        .fifo_st(fifo_st));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic tick(int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Strobes are one-cycle pulses; the extra cycle lets the answer settle.
    task automatic hp(int b, logic [7:0] d);
        host_acc[b] = 1'b1;
        host_acc.wdata = d;
        tick(1);
        host_acc = '0;
        tick(1);
    endtask
    task automatic cp(int b, logic [7:0] d);
        cpu_acc[b] = 1'b1;
        cpu_acc.wdata = d;
        tick(1);
        cpu_acc = '0;
        tick(1);
    endtask
    task automatic fp(int b, int n);
        fm[b] = 1'b1;
        tick(n);
        fm = 4'h0;
        tick(1);
    endtask

    task automatic t_flags;
        int hb[4] = '{12, 11, 8, 14};
        int cb[4] = '{14, 13, 10, 16};
        int eb[4] = '{EVT_MCR_BIT, EVT_LCR_BIT, EVT_FCR_BIT, EVT_THR_BIT};
        for (int i = 0; i < 4; i++) begin
            hp(hb[i], 8'h00);
            chk("flag set", 8'(hes[eb[i]]), 8'h01);
            cp(8, 8'h7f);
            chk("flag kept", 8'(hes[eb[i]]), 8'h01);
            cp(cb[i], 8'h00);
            chk("flag clear", 8'(hes[eb[i]]), 8'h00);
        end
        hp(10, 8'h00);
        hp(9, 8'h00);
        chk("div set", 8'(hes[EVT_DIV_BIT]), 8'h01);
        cp(12, 8'h00);
        chk("div one left", 8'(hes[EVT_DIV_BIT]), 8'h01);
        cp(11, 8'h00);
        chk("div clear", 8'(hes[EVT_DIV_BIT]), 8'h00);
        $display("flags test done");
    endtask

    task automatic t_rbr;
        hp(13, 8'h00);
        chk("rbr set", 8'(hes[EVT_RBR_BIT]), 8'h01);
        cp(15, 8'h00);
        chk("rbr clear", 8'(hes[EVT_RBR_BIT]), 8'h00);
        fifo_mode = 1'b1;
        fp(2, 2);
        fp(3, 2);
        chk("rbr fifo set", 8'(hes[EVT_RBR_BIT]), 8'h01);
        fm[2] = 1'b1;
        cpu_acc.wr_rbr = 1'b1;
        tick(1);
        fm = 4'h0;
        cpu_acc = '0;
        tick(1);
        chk("rbr fifo clear", 8'(hes[EVT_RBR_BIT]), 8'h00);
        fp(3, 1);
        fifo_mode = 1'b0;
        $display("receive flag test done");
    endtask

    task automatic t_dma;
        chk("single tx", 8'(dma_req.host_tx_req), 8'h01);
        fp(0, 1);
        chk("single tx busy", 8'(dma_req.host_tx_req), 8'h00);
        fp(2, 1);
        chk("single rx", 8'(dma_req.host_rx_req), 8'h01);
        fp(3, 1);
        fp(1, 1);
        hp(8, 8'h08);
        chk("multi mode", 8'(multi), 8'h01);
        fp(0, 16);
        chk("multi tx full", 8'(dma_req.host_tx_req), 8'h00);
        fp(1, 16);
        chk("multi tx", 8'(dma_req.host_tx_req), 8'h01);
        fp(2, 3);
        chk("multi rx low", 8'(dma_req.host_rx_req), 8'h00);
        fp(2, 1);
        fp(3, 3);
        chk("multi rx held", 8'(dma_req.host_rx_req), 8'h01);
        fp(3, 1);
        chk("multi rx empty", 8'(dma_req.host_rx_req), 8'h00);
        hp(8, 8'h00);
        chk("single mode", 8'(multi), 8'h00);
        $display("host dma test done");
    endtask

    task automatic t_cpu_idle;
        fp(0, 1);
        chk("no idle yet", 8'(hes[EVT_TXTO_BIT]), 8'h00);
        chk("cpu tx", 8'(dma_req.cpu_tx_req), 8'h01);
        chk("cpu rx", 8'(dma_req.cpu_rx_req), 8'h01);
        dly_en = 1'b1;
        tick(2);
        chk("cpu tx stale", 8'(dma_req.cpu_tx_req), 8'h00);
        sh_upd = 1'b1;
        tick(1);
        sh_upd = 1'b0;
        tick(2);
        chk("cpu tx shadow", 8'(dma_req.cpu_tx_req), 8'h01);
        chk("cpu rx shadow", 8'(dma_req.cpu_rx_req), 8'h01);
        chk("idle set", 8'(hes[EVT_TXTO_BIT]), 8'h01);
        dly_en = 1'b0;
        fp(1, 1);
        chk("idle clear", 8'(hes[EVT_TXTO_BIT]), 8'h00);
        $display("processor dma and idle test done");
    endtask

    task automatic t_ius;
        ius_set = 8'h06;
        tick(1);
        ius_set = 8'h00;
        tick(1);
        chk("in service", hes & 8'h80, 8'h80);
        cp(8, 8'h00);
        chk("write zero", ius_bits, 8'h06);
        cp(8, 8'h80);
        chk("drop first", ius_bits, 8'h04);
        cp(8, 8'h80);
        chk("drop last", hes & 8'h80, 8'h00);
        $display("in-service test done");
    endtask

    // The reader stalls until two snapshots are queued and a third is refused.
    task automatic t_buf;
        hp(11, 8'h00);
        cp(9, 8'h00);
        cp(13, 8'h00);
        cp(9, 8'h00);
        chk("buffer full", 8'(rd_ready), 8'h00);
        cp(9, 8'h00);
        chk("head", rd_data & 8'h04, 8'h04);
        rd_accept = 1'b1;
        tick(1);
        rd_accept = 1'b0;
        chk("second", rd_data & 8'h04, 8'h00);
        tick(1);
        rd_accept = 1'b1;
        tick(1);
        rd_accept = 1'b0;
        chk("drained", {rd_valid, rd_ready}, 8'h01);
        $display("read buffer test done");
    endtask

    task automatic stop_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            stop_test();
        end
    end

    initial begin
        reset = 1'b1;
        host_acc = '0;
        cpu_acc = '0;
        ius_set = 8'h00;
        fm = 4'h0;
        rd_accept = 1'b0;
        fifo_mode = 1'b0;
        dly_en = 1'b0;
        sh_upd = 1'b0;
        tick(3);
        reset = 1'b0;
        tick(1);
        chk("reset flags", hes, 8'h00);
        chk("reset buffer", {multi, rd_valid, rd_ready}, 8'h01);
        t_flags();
        t_rbr();
        t_dma();
        t_cpu_idle();
        t_ius();
        t_buf();
        stop_test();
    end
endmodule // test_ued_event_dma
`default_nettype wire
